/* rtl/hbc_host_port.sv */
`timescale 1ns/1ps
// Operation
// (R1) a cycle starts at a device clock fall with select and strobe both low
// (R2) after recognition the internal bus is requested and won in the low phase
// (R3) data moves in the high phase; the cycle completes when that phase ends
// (R4) select and strobe missing one fall are taken at the next fall
// (R5) host keeps address and write data steady through the high phase
// (R6) service acknowledge is a read of the service vector, qualified by strobe and grant
// (R7) grant cycles and acknowledge-register reads share their own start qualifier
// (R8) with delay select clear, acknowledge follows the rising edge of the transfer phase
// (R9) with delay select set, acknowledge follows the falling edge instead
// (R10) host holds reset for five device clock periods once power and clock settle
// (R11) read data is released promptly once the read strobe returns high
// (R12) shared strobe with direction, or separate read and write strobes, both work
// (R13) host side may run synchronous to the device clock or fully asynchronous
// (R14) a foreign acknowledge cycle passes the grant on and leaves data and ack alone
// (R15) host ends each cycle, strobes and select inactive, before starting another
// (R16) acknowledge holds until select or strobe leaves, so one transfer per strobe; acknowledge-register reads end only when the strobe leaves
// (R17) grant output stays inactive during this device's own acknowledge cycle
module hbc_host_port (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sync_host_i,
  input wire logic split_strobes_i,
  input wire logic ack_delay_select_i,
  input wire logic unit_select_n_i,
  input wire logic transfer_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic chain_grant_in_n_i,
  input wire logic [hbc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [hbc_pkg::DATA_W-1:0] data_i,
  output logic [hbc_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_oe_o,
  output logic chain_grant_out_n_o,
  output logic dev_clk_o,
  input wire logic svc_mine_i,
  input wire logic [hbc_pkg::DATA_W-1:0] svc_vector_i,
  output logic int_req_o,
  input wire logic int_grant_i,
  output logic int_xfer_o,
  output logic int_we_o,
  output logic [hbc_pkg::ADDR_W-1:0] int_addr_o,
  output logic [hbc_pkg::DATA_W-1:0] int_wdata_o,
  input wire logic [hbc_pkg::DATA_W-1:0] int_rdata_i
);
  hbc_pin_if pins ();
  hbc_pkg::hbc_state_t state_q;
  logic [hbc_pkg::DIV_W-1:0] div_q;
  logic phase_q;
  logic fall_en;
  logic rise_en;
  logic cs_act;
  logic stb_act;
  logic strobe_act;
  logic is_read;
  logic grant_in_act;
  logic ack_reg_hit;
  logic svc_start;
  logic ord_start;
  logic done;
  logic svc_q;
  logic read_q;
  logic xfer_q;
  logic ack_q;
  logic ack_rel_q;
  logic data_oe_q;
  logic grant_out_q;
  logic [hbc_pkg::DATA_W-1:0] data_q;
  logic [hbc_pkg::ADDR_W-1:0] addr_q;
  logic [hbc_pkg::DATA_W-1:0] wdata_q;

  // every pin crosses through the filter; the host clock may be unrelated to ours
  assign pins.raw = {data_i, addr_i, chain_grant_in_n_i, wr_strobe_n_i, rd_strobe_n_i,
                     read_not_write_i, transfer_strobe_n_i, unit_select_n_i};

  hbc_pin_filter u_filter (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .sync_host_i(sync_host_i), // [R13]
    .pins(pins)
  );

  // device clock phase from the reference; fall and rise are one-cycle enables
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      div_q <= hbc_pkg::DIV_RST;
      phase_q <= 1'b0;
    end
    else if (div_q == hbc_pkg::DIV_LAST)
    begin
      div_q <= hbc_pkg::DIV_RST;
      phase_q <= ~phase_q;
    end
    else
      div_q <= div_q + 3'h1;
  end

  assign fall_en = (div_q == hbc_pkg::DIV_LAST) && phase_q;
  assign rise_en = (div_q == hbc_pkg::DIV_LAST) && !phase_q;
  assign dev_clk_o = phase_q;

  // decode both handshake styles into one strobe and one direction
  assign cs_act = ~pins.clean[hbc_pkg::PIN_CS];
  assign stb_act = ~pins.clean[hbc_pkg::PIN_STB];
  assign grant_in_act = ~pins.clean[hbc_pkg::PIN_GRANT];
  assign strobe_act = split_strobes_i ? (~pins.clean[hbc_pkg::PIN_RD] | ~pins.clean[hbc_pkg::PIN_WR])
                                      : stb_act; // [R12]
  assign is_read = split_strobes_i ? ~pins.clean[hbc_pkg::PIN_RD] : pins.clean[hbc_pkg::PIN_RW]; // [R12]
  assign ack_reg_hit = pins.clean[hbc_pkg::PIN_ADDR+hbc_pkg::ADDR_W-1 -: hbc_pkg::ADDR_W-2] == hbc_pkg::ACKREG_PAGE;

  // acknowledge cycles get their own qualifier, kept apart from plain reads and writes
  assign svc_start = strobe_act & (grant_in_act | (cs_act & is_read & ack_reg_hit)); // [R6] [R7]
  assign ord_start = cs_act & strobe_act & ~svc_start; // [R1]
  // grant cycles have no select, so only the strobe ends them
  assign done = ~strobe_act | (~svc_q & ~cs_act); // [R15] [R16]

  // cycle sequencer: starts only on a fall enable, so a late strobe waits one period
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= hbc_pkg::ST_IDLE;
      svc_q <= 1'b0;
      read_q <= 1'b0;
      grant_out_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        hbc_pkg::ST_IDLE:
        begin
          if (fall_en) // [R4]
          begin
            if (svc_start && grant_in_act && !svc_mine_i)
            begin
              state_q <= hbc_pkg::ST_PASS; // [R14]
              grant_out_q <= 1'b1;
              svc_q <= 1'b0; // an abandoned own cycle must not look live while passing
            end
            else if (svc_start || ord_start)
            begin
              state_q <= hbc_pkg::ST_ARB; // [R1] [R6]
              svc_q <= svc_start;
              read_q <= is_read | svc_start;
            end
          end
        end
        hbc_pkg::ST_ARB:
        begin
          // a lost arbitration retries at the next rise rather than stretching the phase
          if (done)
            state_q <= hbc_pkg::ST_IDLE;
          else if (rise_en && int_grant_i)
            state_q <= hbc_pkg::ST_XFER; // [R2]
        end
        hbc_pkg::ST_XFER:
        begin
          if (fall_en)
            state_q <= hbc_pkg::ST_ACK; // [R3]
        end
        hbc_pkg::ST_ACK:
        begin
          if (done)
          begin
            state_q <= hbc_pkg::ST_IDLE; // [R16]
            svc_q <= 1'b0;
          end
        end
        hbc_pkg::ST_PASS:
        begin
          if (!strobe_act || !grant_in_act)
          begin
            state_q <= hbc_pkg::ST_IDLE;
            grant_out_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // address and write data taken at the rise; host keeps them steady through the high phase
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      addr_q <= hbc_pkg::ADDR_RST;
      wdata_q <= hbc_pkg::DATA_RST;
      xfer_q <= 1'b0;
    end
    else
    begin
      xfer_q <= (state_q == hbc_pkg::ST_ARB) && rise_en && int_grant_i && !done && !svc_q;
      if ((state_q == hbc_pkg::ST_ARB) && rise_en)
      begin
        addr_q <= pins.clean[hbc_pkg::PIN_ADDR +: hbc_pkg::ADDR_W]; // [R5]
        wdata_q <= pins.clean[hbc_pkg::PIN_DATA +: hbc_pkg::DATA_W]; // [R5]
      end
    end
  end

  assign int_req_o = (state_q == hbc_pkg::ST_ARB); // [R2]
  assign int_xfer_o = xfer_q; // [R3]
  assign int_we_o = ~read_q;
  assign int_addr_o = addr_q;
  assign int_wdata_o = wdata_q;

  // read data captured one cycle into the high phase; dropped as soon as the strobe leaves
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      data_q <= hbc_pkg::DATA_RST;
      data_oe_q <= 1'b0;
    end
    else if (!strobe_act)
      data_oe_q <= 1'b0; // [R11]
    else if ((state_q == hbc_pkg::ST_XFER) && !rise_en && read_q && !data_oe_q)
    begin
      data_q <= svc_q ? svc_vector_i : int_rdata_i; // [R6]
      data_oe_q <= 1'b1;
    end
  end

  assign data_o = data_q;
  assign data_oe_o = data_oe_q;

  // acknowledge timing follows the delay select; held until the host lets go
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ack_q <= 1'b0;
      ack_rel_q <= 1'b0;
    end
    else
    begin
      ack_rel_q <= ack_q;
      if ((state_q == hbc_pkg::ST_ACK) && done)
        ack_q <= 1'b0; // [R16]
      else if ((state_q == hbc_pkg::ST_XFER) && !ack_q)
      begin
        if (!ack_delay_select_i && !fall_en)
          ack_q <= 1'b1; // [R8]
        else if (ack_delay_select_i && fall_en)
          ack_q <= 1'b1; // [R9]
      end
    end
  end

  // active pull-up: drive high one cycle after negation, then let go of the line
  assign transfer_ack_n_o = ~ack_q;
  assign transfer_ack_oe_o = ack_q | ack_rel_q;
  // only a foreign acknowledge cycle passes the grant down the chain
  assign chain_grant_out_n_o = ~grant_out_q; // [R14] [R17]

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_dly_ack;
    (!ack_q) [*2] ##1 ack_q;
  endsequence

  sequence s_arb_enter;
    (state_q == hbc_pkg::ST_IDLE) && fall_en && ord_start;
  endsequence

  start_on_fall_a: assert property (s_arb_enter |=> state_q == hbc_pkg::ST_ARB) // [R1]
    else $error("ordinary cycle not started at fall");
  arb_low_a: assert property ($rose(state_q == hbc_pkg::ST_ARB) |-> !phase_q && int_req_o) // [R2]
    else $error("arbitration outside low phase");
  xfer_high_a: assert property (state_q == hbc_pkg::ST_XFER |-> phase_q) // [R3]
    else $error("transfer outside high phase");
  start_slip_a: assert property ((state_q == hbc_pkg::ST_IDLE) && !fall_en |=> state_q == hbc_pkg::ST_IDLE) // [R4]
    else $error("cycle started between falls");
  svc_start_a: assert property ((state_q == hbc_pkg::ST_IDLE) && fall_en && svc_start && svc_mine_i // [R7]
    |=> (state_q == hbc_pkg::ST_ARB) && svc_q && read_q)
    else $error("service cycle not qualified");
  svc_data_a: assert property ($rose(data_oe_o) && svc_q |-> data_o == $past(svc_vector_i)) // [R6]
    else $error("service read returned wrong vector");
  ack_rise_a: assert property ($rose(state_q == hbc_pkg::ST_XFER) && !ack_delay_select_i |=> ack_q) // [R8]
    else $error("acknowledge late without delay");
  ack_fall_a: assert property ($rose(state_q == hbc_pkg::ST_XFER) && ack_delay_select_i |-> s_dly_ack) // [R9]
    else $error("delayed acknowledge not on fall");
  data_release_a: assert property (data_oe_o && !strobe_act |=> !data_oe_o) // [R11]
    else $error("data bus held after strobe");
  pass_quiet_a: assert property (!chain_grant_out_n_o |-> !data_oe_o && transfer_ack_n_o) // [R14]
    else $error("foreign cycle drove data or ack");
  ack_hold_a: assert property (ack_q && (state_q == hbc_pkg::ST_ACK) && !done |=> ack_q) // [R16]
    else $error("acknowledge dropped early");
  ack_end_a: assert property ((state_q == hbc_pkg::ST_ACK) && done |=> !ack_q ##1 !transfer_ack_oe_o) // [R16]
    else $error("acknowledge not ended");
  own_grant_a: assert property (svc_q && (state_q != hbc_pkg::ST_IDLE) |-> chain_grant_out_n_o) // [R17]
    else $error("grant passed during own cycle");
endmodule : hbc_host_port

/* rtl/hbc_pin_filter.sv */
`timescale 1ns/1ps
module hbc_pin_filter (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sync_host_i,
  hbc_pin_if.flt pins
);
  // one three-stage chain per pin; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < hbc_pkg::PIN_W; gi++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic hold_q;
      always_ff @(posedge ref_clk_i)
      begin
        if (reset_i)
        begin
          s1_q <= hbc_pkg::PIN_IDLE[gi];
          s2_q <= hbc_pkg::PIN_IDLE[gi];
          s3_q <= hbc_pkg::PIN_IDLE[gi];
          hold_q <= hbc_pkg::PIN_IDLE[gi];
        end
        else
        begin
          s1_q <= pins.raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            hold_q <= s3_q;
        end
      end
      // a host clocked from the device clock skips the agreement stage to save latency
      assign pins.clean[gi] = sync_host_i ? s2_q : hold_q;
    end
  endgenerate
endmodule : hbc_pin_filter

/* rtl/hbc_pin_if.sv */
`timescale 1ns/1ps
interface hbc_pin_if;
  logic [hbc_pkg::PIN_W-1:0] raw;
  logic [hbc_pkg::PIN_W-1:0] clean;
  modport drv (output raw, input clean);
  modport flt (input raw, output clean);
endinterface : hbc_pin_if

/* rtl/hbc_pkg.sv */
package hbc_pkg;
  // pin vector layout shared by the top and the input filter
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PIN_CS = 0;
  localparam int PIN_STB = 1;
  localparam int PIN_RW = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_WR = 4;
  localparam int PIN_GRANT = 5;
  localparam int PIN_ADDR = 6;
  localparam int PIN_DATA = PIN_ADDR + ADDR_W;
  localparam int PIN_W = PIN_DATA + DATA_W;
  // idle level: every active-low strobe high, direction low
  localparam logic [PIN_W-1:0] PIN_IDLE = 21'h00003B;

  // device clock phase timing, derived from the 125 MHz reference
  localparam int REF_MHZ = 125;
  localparam int DEV_HALF_NS = 16;
  localparam int DEV_HALF_RAW = (DEV_HALF_NS * REF_MHZ) / 1000;
  localparam int DEV_HALF_CYC = (DEV_HALF_RAW < 1) ? 1 : DEV_HALF_RAW;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DEV_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
  // least reset hold, in device clock periods
  localparam int RESET_MIN_PERIODS = 5;

  // acknowledge registers occupy one 4-entry page of the address space
  localparam logic [ADDR_W-3:0] ACKREG_PAGE = 5'h1F;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARB,
    ST_XFER,
    ST_ACK,
    ST_PASS
  } hbc_state_t;
endpackage : hbc_pkg

/* test/clocked_host_bus_cycle_tb_top.sv */
`timescale 1ns/1ps
module clocked_host_bus_cycle_tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sync_host = 1'b1, split = 1'b0, dly = 1'b0, mine = 1'b0, grant = 1'b1;
  logic [7:0] vec = 8'hC3;
  wire cs_n, stb_n, rnw, rd_n, wr_n, gin_n;
  wire [6:0] addr;
  wire [7:0] wd;
  logic [7:0] dout, iwd, irdata;
  logic [6:0] iaddr;
  logic oe, ack_n, ack_oe, cgo_n, ireq, ixfer, iwe, last_we, oe_any, cgo_any;
  logic dclk, xfer_dclk;
  logic prev_ack = 1'b1;
  int n_fail = 0, cmp_count = 0, cyc = 0, xfer_n = 0, xfer_at = 0, ack_at = 0;
  wire ack_w = ack_oe ? ack_n : 1'b1; // pull-up holds a released ack high
  wire [7:0] rbus = oe ? dout : ~dout;
  assign irdata = 8'h5A ^ {1'b0, iaddr};

  always #4 ref_clk_i = ~ref_clk_i;

  hbc_host_port i_hbc_host_port (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sync_host_i(sync_host),
    .split_strobes_i(split), .ack_delay_select_i(dly), .unit_select_n_i(cs_n), .transfer_strobe_n_i(stb_n),
    .read_not_write_i(rnw), .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n), .chain_grant_in_n_i(gin_n),
    .addr_i(addr), .data_i(wd), .data_o(dout), .data_oe_o(oe), .transfer_ack_n_o(ack_n),
    .transfer_ack_oe_o(ack_oe), .chain_grant_out_n_o(cgo_n), .dev_clk_o(dclk), .svc_mine_i(mine),
    .svc_vector_i(vec), .int_req_o(ireq), .int_grant_i(grant), .int_xfer_o(ixfer), .int_we_o(iwe),
    .int_addr_o(iaddr), .int_wdata_o(iwd), .int_rdata_i(irdata));

  hbc_host_model i_hbc_host_model (.ref_clk_i(ref_clk_i), .split_i(split), .ack_w_i(ack_w), .cgo_n_i(cgo_n),
    .oe_i(oe), .rdata_i(rbus), .cs_n_o(cs_n), .stb_n_o(stb_n), .rnw_o(rnw), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .gin_n_o(gin_n), .addr_o(addr), .wdata_o(wd));

  // watch internal transfers and the ack edge, in cycle numbers
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (ixfer)
    begin
      xfer_n++;
      xfer_at = cyc;
      last_we = iwe;
      xfer_dclk = dclk;
    end
    if (prev_ack && !ack_w) ack_at = cyc;
    prev_ack = ack_w;
    if (oe) oe_any = 1'b1;
    if (!cgo_n) cgo_any = 1'b1;
  end

  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one host cycle, with got and release checked every time
  task automatic run(input logic svc, input logic rd, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] rv);
    logic got, idle;
    oe_any = 1'b0;
    cgo_any = 1'b0;
    i_hbc_host_model.cyc(svc, rd, a, d, rv, got, idle);
    check("answer", {15'h0, got}, 16'h0001);
    check("release", {15'h0, idle}, 16'h0001);
  endtask : run

  task automatic t_ordinary(input logic rd, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rv;
    int x0;
    x0 = xfer_n;
    run(1'b0, rd, a, d, rv);
    check("xfers", 16'(xfer_n - x0), 16'h0001);
    check("we", {15'h0, last_we}, {15'h0, !rd});
    check("xfer phase", {15'h0, xfer_dclk}, 16'h0001);
    check("ack lag", 16'(ack_at - xfer_at), dly ? 16'h0002 : 16'h0001);
    if (rd)
      check("rdata", {8'h0, rv}, {8'h0, 8'h5A ^ {1'b0, a}});
    else
      check("wdata", {1'b0, iaddr, iwd}, {1'b0, a, d});
  endtask : t_ordinary

  task automatic t_styles;
    t_ordinary(1'b1, 7'h12, 8'h00);
    dly = 1'b1;
    t_ordinary(1'b0, 7'h13, 8'h3C);
    split = 1'b1;
    t_ordinary(1'b1, 7'h00, 8'h00);
    dly = 1'b0;
    t_ordinary(1'b0, 7'h7B, 8'hFF);
    split = 1'b0;
    sync_host = 1'b0;
    t_ordinary(1'b1, 7'h40, 8'h00);
    sync_host = 1'b1;
  endtask : t_styles

  task automatic t_service;
    logic [7:0] rv;
    int a0;
    mine = 1'b1;
    run(1'b1, 1'b1, 7'h05, 8'h00, rv);
    check("vector", {8'h0, rv}, {8'h0, vec});
    check("grant out own", {15'h0, cgo_any}, 16'h0000);
    mine = 1'b0;
    vec = 8'h96;
    run(1'b0, 1'b1, 7'h7C, 8'h00, rv);
    check("ackreg vector", {8'h0, rv}, {8'h0, vec});
    a0 = ack_at;
    run(1'b1, 1'b1, 7'h06, 8'h00, rv);
    check("grant out", {15'h0, cgo_any}, 16'h0001);
    check("no drive", {15'h0, oe_any}, 16'h0000);
    check("no ack", 16'(ack_at - a0), 16'h0000);
  endtask : t_service

  // internal bus withheld: no transfer until grant, request held meanwhile
  task automatic t_grant_wait;
    int x0;
    x0 = xfer_n;
    grant = 1'b0;
    fork
      t_ordinary(1'b1, 7'h2A, 8'h00);
      begin
        repeat (14) @(negedge ref_clk_i);
        check("req held", {15'h0, ireq}, 16'h0001);
        check("no xfer", 16'(xfer_n - x0), 16'h0000);
        grant = 1'b1;
      end
    join
  endtask : t_grant_wait

  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(negedge ref_clk_i); // five device periods
    reset_i = 1'b0;
    t_styles();
    t_service();
    t_grant_wait();
    stop_test();
  end
endmodule : clocked_host_bus_cycle_tb_top

/* test/hbc_host_model.sv */
`timescale 1ns/1ps
// host side: one cycle at a time, each fully ended before the next
module hbc_host_model (
  input wire logic ref_clk_i,
  input wire logic split_i,
  input wire logic ack_w_i,
  input wire logic cgo_n_i,
  input wire logic oe_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic stb_n_o,
  output logic rnw_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic gin_n_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  // idle pins at time zero
  initial
  begin
    {cs_n_o, stb_n_o, rd_n_o, wr_n_o, gin_n_o} = 5'h1F;
    rnw_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end

  // held until ack or grant-out seen, for at most 64 cycles, so slow chains are waited out
  task automatic cyc(input logic svc, input logic rd, input logic [6:0] a, input logic [7:0] wd,
                     output logic [7:0] rv, output logic got, output logic idle);
    int n;
    @(negedge ref_clk_i);
    addr_o = a; // address and data held through the high phase
    wdata_o = wd;
    rnw_o = rd;
    cs_n_o = svc; // grant cycles leave select high
    gin_n_o = !svc;
    stb_n_o = split_i; // either strobe style
    rd_n_o = !(split_i && rd);
    wr_n_o = !(split_i && !rd);
    got = 1'b0;
    rv = 8'h00;
    for (n = 0; n < 64 && !got; n++)
    begin
      @(posedge ref_clk_i);
      got = !ack_w_i || !cgo_n_i;
      rv = rdata_i;
    end
    @(negedge ref_clk_i);
    {cs_n_o, stb_n_o, rd_n_o, wr_n_o, gin_n_o} = 5'h1F;
    addr_o = ~a; // released lines do not keep the old value
    wdata_o = ~wd;
    idle = 1'b0;
    for (n = 0; n < 16 && !idle; n++)
    begin
      @(posedge ref_clk_i);
      idle = ack_w_i && cgo_n_i && !oe_i;
    end
    // hand back off the sampling edge so callers change inputs safely
    @(negedge ref_clk_i);
  endtask : cyc
endmodule : hbc_host_model
